// File: srs_params.svh
// Timing counts for the staged reset release sequencer
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

// Power-on extender length, oscillator clock cycles
`define SRS_POR_EXT_CYC 64
// Software and watchdog reset logic hold, oscillator clock cycles
`define SRS_SYNC_GEN_CYC 3
// Clock-generation reset extension, oscillator clock cycles
`define SRS_CLKGEN_CYC 32
// Peripheral reset extension, system clock cycles
`define SRS_PERIP_CYC 32
// Core reset extension, system clock cycles
`define SRS_CORE_CYC 32
// Extender counter width
`define SRS_CNT_W 7
// Width of the elapsed-cycle monitors
`define SRS_MON_W 8

`endif

// File: srs_pkg.sv
// Types for the staged reset release sequencer
`include "srs_params.svh"

package srs_pkg;

   typedef logic [`SRS_MON_W-1:0] srs_mon_t;

   // Gray coded along the release path
   typedef enum logic [2:0] {
      PH_POR = 3'h0,
      PH_HOLD = 3'h1,
      PH_CLKGEN = 3'h3,
      PH_PERIPH = 3'h2,
      PH_CORE = 3'h6,
      PH_RUN = 3'h7
   } srs_phase_e;

   typedef struct packed {
      logic por_meta;
      logic por_sync;
      logic ext_meta;
      logic ext_sync;
      logic sw_flag;
      logic tor_flag;
      logic lor_flag;
      srs_phase_e phase;
      srs_mon_t mon_por;
      srs_mon_t mon_comb;
      srs_mon_t mon_per;
      srs_mon_t mon_core;
   } srs_state_s;

   localparam srs_state_s SRS_STATE_RST = '0;

endpackage : srs_pkg

// File: srs_rel_ext.sv
// Reset extender: releases after a set number of ticks free of hold
`timescale 1ns/100ps

module srs_rel_ext #(
   parameter int CYCLES = 32,
   parameter int W = 7
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hold,
   input wire logic tick,
   output logic released
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic rel;
   } srs_ext_s;

   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   generate
      if (CYCLES < 1 || CYCLES > (1 << W)) begin : g_bad
         $error("srs_rel_ext: CYCLES does not fit the counter");
      end
   endgenerate

   srs_ext_s s_ff;
   srs_ext_s nxt_s;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s = s_ff;
      if (hold) begin
         nxt_s = '0; // R18
      end else if (!s_ff.rel && tick) begin
         if (s_ff.cnt == LAST) begin
            nxt_s.rel = 1'b1;
         end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign released = s_ff.rel;

   ////////////////////////////////////////////////////////////////////////
   hold_clears_rel_a: assert property ( // R18
      @(posedge ref_clk) disable iff (!resetn)
      hold |=> !released && s_ff.cnt == '0)
      else $error("extender not restarted by hold");

endmodule : srs_rel_ext

// File: srs_staged_reset.sv
// Staged reset release sequencer top
`timescale 1ns/100ps
`include "srs_params.svh"

// Notes on behaviour
// R1: Five sources: two asynchronous, three synchronous
// R2: Software reset comes from control write
// R3: Test circuitry reset by power-on only
// R4: Power-on stretched 64 oscillator cycles
// R5: Combined reset ORs extended, external, watchdog, software
// R6: Control and extenders run after combined release
// R7: Software/watchdog logic held three cycles more
// R8: Clock-generation reset released after 32 cycles
// R9: Clock-generation release aligned to oscillator clock
// R10: Peripheral reset 32 system cycles later
// R11: Core reset 32 system cycles later
// R12: Peripheral extender idle until clock-generation release
// R13: Core extender idle until peripheral release
// R14: Peripheral and core release on clock edge
// R15: Core runs only after core release
// R16: Early stages timed by oscillator clock
// R17: No interrupt requests raised
// R18: Asynchronous sources assert resets at once; counters restart
module srs_staged_reset
   import srs_pkg::*;
#(
   parameter int POR_EXT_CYC = `SRS_POR_EXT_CYC,
   parameter int SYNC_GEN_CYC = `SRS_SYNC_GEN_CYC,
   parameter int CLKGEN_CYC = `SRS_CLKGEN_CYC,
   parameter int PERIP_CYC = `SRS_PERIP_CYC,
   parameter int CORE_CYC = `SRS_CORE_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic por_n,
   input wire logic ext_reset_n,
   input wire logic sw_reset_req,
   input wire logic watchdog_timeout_reset,
   input wire logic watchdog_lost_reference_reset,
   input wire logic system_clock_tick,
   output logic ext_por_reset,
   output logic combined_reset,
   output logic sync_logic_reset,
   output logic clock_gen_reset,
   output logic peripheral_reset,
   output logic core_reset,
   output logic jtag_reset,
   output logic core_run,
   output logic [2:0] startup_phase
);

   localparam int MON_MAX = (1 << `SRS_MON_W) - 1;

   generate
      if (POR_EXT_CYC < 1 || POR_EXT_CYC >= MON_MAX ||
          SYNC_GEN_CYC < 1 || SYNC_GEN_CYC >= MON_MAX ||
          CLKGEN_CYC < 1 || CLKGEN_CYC >= MON_MAX ||
          PERIP_CYC < 1 || PERIP_CYC >= MON_MAX ||
          CORE_CYC < 1 || CORE_CYC >= MON_MAX) begin : g_bad
         $error("srs_staged_reset: extension length out of range");
      end
   endgenerate

   srs_state_s s_ff;
   srs_state_s nxt_s;

   logic por_ext_rel;
   logic sync_rel;
   logic clkgen_rel;
   logic peri_rel;
   logic core_rel;
   logic comb_hold;
   logic raw_assert;

   function automatic srs_mon_t mon_step(input srs_mon_t v,
                                         input logic clr,
                                         input logic inc);
      srs_mon_t r;
      r = v;
      if (clr) begin
         r = '0;
      end else if (inc && v != srs_mon_t'(MON_MAX)) begin
         r = v + 1'b1;
      end
      return r;
   endfunction : mon_step

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous sources, immediate assertion path
   assign raw_assert = !por_n || !ext_reset_n; // R1 R18

   // Combined reset from synchronised sources and latched requests
   assign comb_hold = !por_ext_rel || !s_ff.ext_sync || s_ff.sw_flag ||
                      s_ff.tor_flag || s_ff.lor_flag; // R5

   ////////////////////////////////////////////////////////////////////////
   // Power-on extender, oscillator timed
   srs_rel_ext #(
      .CYCLES(POR_EXT_CYC),
      .W(`SRS_CNT_W)
   ) u_por_ext (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .hold(!s_ff.por_sync), // R4
      .tick(1'b1), // R16
      .released(por_ext_rel)
   );

   // Hold for software and watchdog reset logic
   srs_rel_ext #(
      .CYCLES(SYNC_GEN_CYC),
      .W(`SRS_CNT_W)
   ) u_sync_gen (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .hold(comb_hold), // R6 R7
      .tick(1'b1), // R16
      .released(sync_rel)
   );

   // Clock-generation extender; release on an oscillator edge
   srs_rel_ext #(
      .CYCLES(CLKGEN_CYC),
      .W(`SRS_CNT_W)
   ) u_clkgen_ext (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .hold(comb_hold), // R6 R8
      .tick(1'b1), // R9 R16
      .released(clkgen_rel)
   );

   // Peripheral extender counts system clock cycles
   srs_rel_ext #(
      .CYCLES(PERIP_CYC),
      .W(`SRS_CNT_W)
   ) u_perip_ext (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .hold(comb_hold || !clkgen_rel), // R12 R18
      .tick(system_clock_tick), // R10 R14
      .released(peri_rel)
   );

   // Core extender counts system clock cycles
   srs_rel_ext #(
      .CYCLES(CORE_CYC),
      .W(`SRS_CNT_W)
   ) u_core_ext (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .hold(comb_hold || !peri_rel), // R13 R18
      .tick(system_clock_tick), // R11 R14
      .released(core_rel)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_s = s_ff;
      // Pin synchronisers
      nxt_s.por_meta = por_n;
      nxt_s.por_sync = s_ff.por_meta;
      nxt_s.ext_meta = ext_reset_n;
      nxt_s.ext_sync = s_ff.ext_meta;
      // Synchronous sources, live only while their logic is released
      nxt_s.sw_flag = sync_rel && (s_ff.sw_flag || sw_reset_req); // R2 R7
      nxt_s.tor_flag = sync_rel &&
                       (s_ff.tor_flag || watchdog_timeout_reset); // R1 R7
      nxt_s.lor_flag = sync_rel &&
                       (s_ff.lor_flag ||
                        watchdog_lost_reference_reset); // R1 R7
      // Start-up phase tracking
      case (s_ff.phase)
         PH_POR: begin
            if (por_ext_rel) begin
               nxt_s.phase = PH_HOLD;
            end
         end
         PH_HOLD: begin
            if (!por_ext_rel) begin
               nxt_s.phase = PH_POR;
            end else if (!comb_hold) begin
               nxt_s.phase = PH_CLKGEN;
            end
         end
         PH_CLKGEN: begin
            if (comb_hold) begin
               nxt_s.phase = PH_HOLD;
            end else if (clkgen_rel) begin
               nxt_s.phase = PH_PERIPH;
            end
         end
         PH_PERIPH: begin
            if (comb_hold) begin
               nxt_s.phase = PH_HOLD;
            end else if (peri_rel) begin
               nxt_s.phase = PH_CORE;
            end
         end
         PH_CORE: begin
            if (comb_hold) begin
               nxt_s.phase = PH_HOLD;
            end else if (core_rel) begin
               nxt_s.phase = PH_RUN;
            end
         end
         PH_RUN: begin
            if (comb_hold) begin
               nxt_s.phase = PH_HOLD;
            end
         end
         default: begin
            nxt_s.phase = PH_POR;
         end
      endcase
      if (!s_ff.por_sync) begin
         nxt_s.phase = PH_POR;
      end
      // Elapsed-cycle monitors
      nxt_s.mon_por = mon_step(s_ff.mon_por, !s_ff.por_sync, 1'b1);
      nxt_s.mon_comb = mon_step(s_ff.mon_comb, comb_hold, 1'b1);
      nxt_s.mon_per = mon_step(s_ff.mon_per, comb_hold || !clkgen_rel,
                               system_clock_tick);
      nxt_s.mon_core = mon_step(s_ff.mon_core, comb_hold || !peri_rel,
                                system_clock_tick);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_ff <= SRS_STATE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; no interrupt output exists
   assign ext_por_reset = !por_n || !por_ext_rel; // R4 R18
   assign combined_reset = raw_assert || comb_hold; // R5 R18
   // Combined reset holds every stage in the same cycle
   assign sync_logic_reset = raw_assert || comb_hold || !sync_rel; // R7 R18
   assign clock_gen_reset = raw_assert || comb_hold || !clkgen_rel; // R8 R18
   assign peripheral_reset = raw_assert || comb_hold || !peri_rel; // R10 R18
   assign core_reset = raw_assert || comb_hold || !core_rel; // R11 R18
   assign jtag_reset = !por_n || !s_ff.por_sync; // R3
   assign core_run = (s_ff.phase == PH_RUN) && !raw_assert &&
                     !comb_hold; // R15 R17
   assign startup_phase = s_ff.phase;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_pins_quiet;
      por_n && ext_reset_n;
   endsequence

   sequence s_sw_taken;
      sw_reset_req && !sync_logic_reset && !comb_hold;
   endsequence

   sequence s_sw_effect;
      combined_reset ##1 sync_logic_reset && clock_gen_reset;
   endsequence

   por_ext_hold_a: assert property ( // R4
      s_ff.por_sync && s_ff.mon_por < POR_EXT_CYC |-> ext_por_reset)
      else $error("power-on stretch released early");

   por_ext_rel_a: assert property ( // R4
      s_pins_quiet and s_ff.mon_por >= POR_EXT_CYC |-> !ext_por_reset)
      else $error("power-on stretch held too long");

   comb_or_a: assert property ( // R5
      ext_por_reset || s_ff.sw_flag || s_ff.tor_flag ||
      s_ff.lor_flag || !ext_reset_n |-> combined_reset &&
      clock_gen_reset && peripheral_reset && core_reset)
      else $error("combined reset missing a source");

   sync_hold_a: assert property ( // R7
      !comb_hold && s_ff.mon_comb < SYNC_GEN_CYC |-> sync_logic_reset)
      else $error("sync logic released early");

   sync_rel_a: assert property ( // R7
      s_pins_quiet and !comb_hold && s_ff.mon_comb >= SYNC_GEN_CYC
      |-> !sync_logic_reset)
      else $error("sync logic released late");

   clkgen_len_a: assert property ( // R8
      s_pins_quiet and !comb_hold |->
      (clock_gen_reset == (s_ff.mon_comb < CLKGEN_CYC)))
      else $error("clock-generation release at wrong count");

   perip_len_a: assert property ( // R10
      s_pins_quiet and clkgen_rel |->
      (peripheral_reset == (comb_hold || s_ff.mon_per < PERIP_CYC)))
      else $error("peripheral release at wrong count");

   core_len_a: assert property ( // R11
      s_pins_quiet and peri_rel |->
      (core_reset == (comb_hold || s_ff.mon_core < CORE_CYC)))
      else $error("core release at wrong count");

   stage_order_a: assert property ( // R12 R13
      (!peripheral_reset |-> !clock_gen_reset) and
      (!core_reset |-> !peripheral_reset))
      else $error("reset stages released out of order");

   jtag_por_only_a: assert property ( // R3
      s_ff.por_sync && por_n && combined_reset |-> !jtag_reset)
      else $error("test reset from a non power-on source");

   sw_reset_path_a: assert property ( // R2
      s_sw_taken |=> s_sw_effect)
      else $error("software reset not applied");

   wdog_reset_a: assert property ( // R1
      watchdog_timeout_reset && !sync_logic_reset && !comb_hold
      |=> combined_reset ##1 core_reset)
      else $error("watchdog reset not applied");

   async_now_a: assert property ( // R18
      !por_n || !ext_reset_n |->
      (ext_por_reset == (!por_n || !por_ext_rel)) ##0
      (combined_reset && sync_logic_reset &&
      clock_gen_reset && peripheral_reset && core_reset))
      else $error("asynchronous source did not assert resets");

   wdog_lor_a: assert property ( // R1
      watchdog_lost_reference_reset && !sync_logic_reset && !comb_hold
      |=> combined_reset ##1 core_reset)
      else $error("lost-reference reset not applied");

   core_hold_a: assert property ( // R15
      core_run |-> !core_reset && !peripheral_reset && !clock_gen_reset)
      else $error("core running while held in reset");

   core_run_a: assert property ( // R15
      $rose(core_run) |-> !core_reset && $past(core_rel))
      else $error("core ran before core reset release");

endmodule : srs_staged_reset

// File: srs_src_model.sv
// Reset source model: power-on detector, reset pin, watchdog
`timescale 1ns/100ps

module srs_src_model (
   input wire logic ref_clk,
   input wire logic por_hold,
   input wire logic ext_hold,
   input wire logic [1:0] wd_fire,
   output logic por_n,
   output logic ext_reset_n,
   output logic watchdog_timeout_reset,
   output logic watchdog_lost_reference_reset
);
   initial begin
      por_n = 1'b0;
      ext_reset_n = 1'b1;
      watchdog_timeout_reset = 1'b0;
      watchdog_lost_reference_reset = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // Pins move off the clock edge, like real asynchronous sources
   always @(posedge ref_clk) begin
      por_n <= #3 !por_hold;
      ext_reset_n <= #3 !ext_hold;
   end
   // Watchdog requests are one-cycle pulses
   always @(posedge ref_clk) begin
      watchdog_timeout_reset <= (wd_fire == 2'h1);
      watchdog_lost_reference_reset <= (wd_fire == 2'h2);
   end
endmodule : srs_src_model

// File: staged_reset_release_sequencer_tb.sv
// Self-checking bench for the staged reset release sequencer
`timescale 1ns/100ps

module staged_reset_release_sequencer_tb
   import srs_pkg::*;
;
   localparam int POR = 8;
   localparam int SYNC = 3;
   localparam int CLKGEN = 6;
   localparam int PERIP = 5;
   localparam int CORE = 4;
   localparam int LIMIT = 5000;
   logic ref_clk, resetn, sw_reset_req, dense;
   logic system_clock_tick = 1'b0;
   logic por_hold, ext_hold;
   logic [1:0] wd_fire;
   logic por_n, ext_reset_n, wd_tor, wd_lor;
   logic ext_por_reset, combined_reset, sync_logic_reset;
   logic clock_gen_reset, peripheral_reset, core_reset;
   logic jtag_reset, core_run;
   logic [2:0] startup_phase;
   logic [16:0] lfsr = 17'h160ef;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   int k;

   srs_src_model src (.ref_clk(ref_clk), .por_hold(por_hold),
      .ext_hold(ext_hold), .wd_fire(wd_fire), .por_n(por_n),
      .ext_reset_n(ext_reset_n), .watchdog_timeout_reset(wd_tor),
      .watchdog_lost_reference_reset(wd_lor));

   srs_staged_reset #(.POR_EXT_CYC(POR), .SYNC_GEN_CYC(SYNC),
      .CLKGEN_CYC(CLKGEN), .PERIP_CYC(PERIP), .CORE_CYC(CORE)) uut (
      .ref_clk(ref_clk), .resetn(resetn), .por_n(por_n),
      .ext_reset_n(ext_reset_n), .sw_reset_req(sw_reset_req),
      .watchdog_timeout_reset(wd_tor),
      .watchdog_lost_reference_reset(wd_lor),
      .system_clock_tick(system_clock_tick),
      .ext_por_reset(ext_por_reset), .combined_reset(combined_reset),
      .sync_logic_reset(sync_logic_reset),
      .clock_gen_reset(clock_gen_reset),
      .peripheral_reset(peripheral_reset), .core_reset(core_reset),
      .jtag_reset(jtag_reset), .core_run(core_run),
      .startup_phase(startup_phase));

   ////////////////////////////////////////////////////////////////////
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr_next

   function automatic logic por_window(input int f);
      return (f >= POR) && (f <= POR + 3);
   endfunction : por_window

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic wait_core(input logic v);
      int c;
      for (c = 0; c < 2000 && core_reset !== v; c++)
         @(negedge ref_clk);
      chk(core_reset, v);
   endtask : wait_core

   // Follows one full release; combined through core resets are high on entry
   task automatic watch(input logic from_por);
      int c, i, tk_p, tk_c;
      int f[6];
      logic [5:0] v;
      logic jt;
      f = '{default: -1};
      tk_p = 0;
      tk_c = 0;
      jt = 1'b0;
      for (c = 0; c < 2000 && core_run !== 1'b1; c++) begin
         @(negedge ref_clk);
         v = {core_reset, peripheral_reset, clock_gen_reset,
              sync_logic_reset, combined_reset, ext_por_reset};
         for (i = 0; i < 6; i++)
            if (f[i] < 0 && v[i] === 1'b0) f[i] = c;
         if (!v[3] && v[4] && system_clock_tick === 1'b1) tk_p++;
         if (!v[4] && v[5] && system_clock_tick === 1'b1) tk_c++;
         if (jtag_reset === 1'b1) jt = 1'b1;
      end
      chk(core_run, 1'b1);
      chk(c - 1 - f[5], 1);
      chk(startup_phase, PH_RUN);
      chk(f[2] - f[1], SYNC);
      chk(f[3] - f[1], CLKGEN);
      chk(tk_p, PERIP);
      chk(tk_c, CORE);
      chk(f[4] > f[3] && f[5] > f[4], 1'b1);
      chk(jt, from_por);
      if (from_por) begin
         chk(por_window(f[0]), 1'b1);
         chk(f[1], f[0]);
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Random ticks stand in for a slow system clock; while dense is set a tick comes every cycle
   always @(posedge ref_clk) begin
      lfsr <= lfsr_next(lfsr);
      system_clock_tick <= dense | lfsr[0];
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      resetn = 1'b0;
      por_hold = 1'b1;
      ext_hold = 1'b0;
      wd_fire = 2'h0;
      sw_reset_req = 1'b0;
      dense = 1'b1;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      por_hold <= 1'b0;
      watch(1'b1);
      $display("test power_on done");
      dense = 1'b0;
      // Software, watchdog time-out, watchdog lost reference
      for (k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         if (k == 0) sw_reset_req <= 1'b1;
         else wd_fire <= k[1:0];
         @(posedge ref_clk);
         sw_reset_req <= 1'b0;
         wd_fire <= 2'h0;
         wait_core(1'b1);
         watch(1'b0);
      end
      $display("test sync_sources done");
      @(posedge ref_clk);
      sw_reset_req <= 1'b1;
      @(posedge ref_clk);
      sw_reset_req <= 1'b0;
      wait_core(1'b1);
      for (k = 0; k < 2000 && clock_gen_reset !== 1'b0; k++)
         @(negedge ref_clk);
      @(posedge ref_clk);
      ext_hold <= 1'b1;
      @(negedge ext_reset_n);
      #1;
      chk({jtag_reset, combined_reset, clock_gen_reset, peripheral_reset,
           core_reset, core_run}, 6'h1e);
      repeat (3) @(posedge ref_clk);
      ext_hold <= 1'b0;
      watch(1'b0);
      $display("test pin_abort done");
      @(posedge ref_clk);
      ext_hold <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_hold <= 1'b0;
      for (k = 0; k < 50 && combined_reset !== 1'b0; k++)
         @(negedge ref_clk);
      @(posedge ref_clk);
      sw_reset_req <= 1'b1;
      @(posedge ref_clk);
      sw_reset_req <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(combined_reset, 1'b0);
      wait_core(1'b0);
      $display("test early_request done");
      @(posedge ref_clk);
      por_hold <= 1'b1;
      @(negedge por_n);
      #1;
      chk({jtag_reset, ext_por_reset, core_reset}, 3'h7);
      repeat (3) @(posedge ref_clk);
      por_hold <= 1'b0;
      watch(1'b1);
      $display("test power_on_again done");
      summarize();
   end
endmodule : staged_reset_release_sequencer_tb
